// ---- hdl/ccr_receiver_monitor.sv ----
// two composite clock receivers with monitors and register port
//
// Function
// R1 - input is 64kHz AMI with a bipolar violation every eighth bit
// R2 - recognise the 400Hz marker given by an omitted violation
// R3 - recover 8kHz clock from markers and forward only that clock
// R4 - edge select: clock falls at violation or at following pulse
// R5 - loss of signal or AMI violation latches flag, interrupts if enabled
// R6 - loss of signal after 32us with no pulse
// R7 - AMI violation after pattern breaks in two consecutive 8-bit periods
// R8 - single break counts to leaky bucket when that option is set
// R9 - AMI invalidate option marks the clock invalid on AMI violation
// R10 - LOS invalidate option marks the clock invalid on loss of signal
// R11 - no violation for 500us latches missing-8kHz flag, always running
// R12 - no clock forwarded while the 8kHz component is absent
// R13 - no omitted marker for 5ms latches missing-400Hz flag, always running
// R14 - with 8kHz gone the AMI flag keeps being set again
// R15 - missing 400Hz neither sets AMI flag nor invalidates clock
// R16 - software masks AMI interrupt while missing-8kHz flag stands
// R17 - software may disable component interrupts and ignore those flags
// R18 - flags stay set until cleared; interrupt holds while enabled flag set
`timescale 1ns/1ps
`include "ccr_map.svh"
module ccr_receiver_monitor #(
	parameter int AW = 8,
	parameter int DW = 8,
	parameter int unsigned LOS_CYC = `CCR_LOS_US * (`CCR_REF_HZ / 1000000),
	parameter int unsigned NO8_CYC = `CCR_NO8_US * (`CCR_REF_HZ / 1000000),
	parameter int unsigned NO4_CYC = `CCR_NO4_MS * (`CCR_REF_HZ / 1000),
	parameter int unsigned HALF_CYC = `CCR_REF_HZ / (2 * `CCR_FRAME_HZ)
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// line comparators
	input wire logic composite_input_one_pos,
	input wire logic composite_input_one_neg,
	input wire logic composite_input_two_pos,
	input wire logic composite_input_two_neg,
	// register port
	input wire logic [AW-1:0] reg_addr,
	input wire logic [DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DW-1:0] reg_rdata,
	// to clock monitoring and selection
	output logic [1:0] recovered_clk,
	output logic [1:0] clock_invalid,
	output logic [1:0] bucket_inc,
	// interrupt
	output logic interrupt_request_pin
);
	localparam int NT = 6;

	ccr_pkg::ccr_evt_s evt [2];
	ccr_pkg::ccr_ctrl_s ctrl_q;
	logic [1:0] line_pos;
	logic [1:0] line_neg;
	logic [3:0] lf_stat_q;
	logic [3:0] lf_en_q;
	logic [3:0] cl_stat_q;
	logic [3:0] cl_en_q;
	logic [3:0] lf_set;
	logic [3:0] cl_set;
	logic [NT-1:0] tmr_restart;
	logic [NT-1:0] tmr_exp_q;
	logic [1:0] los;
	logic [1:0] no8;
	logic [1:0] no4;
	logic [1:0] ami_evt;
	logic [1:0] ami_act;
	logic [1:0] marker;
	logic [1:0] fall;
	logic [1:0] after_q;
	logic [1:0] clk8_q;
	logic [DW-1:0] rd_mux;
	logic wr_ctrl, wr_lf_clr, wr_lf_en;
	logic wr_cl_clr, wr_cl_en;
	logic [1:0] fall_ok;
	logic [3:0] lf_clr;
	logic [3:0] cl_clr;
	logic lf_irq;
	logic cl_irq;
	logic [7:0] live;
	logic [4:0] ctrl_rd;

	assign line_pos = {composite_input_two_pos, composite_input_one_pos};
	assign line_neg = {composite_input_two_neg, composite_input_one_neg};

	// per-line decoding, clock recovery
	for (genvar ch = 0; ch < 2; ch++) begin : g_ch
		logic [31:0] half_q;

		ccr_line_decode u_dec (
			.ref_clk(ref_clk),
			.reset(reset),
			.line_pos(line_pos[ch]),
			.line_neg(line_neg[ch]),
			.evt_q(evt[ch])
		);

		assign ami_evt[ch] = evt[ch].ami;
		assign ami_act[ch] = evt[ch].ami_act;
		assign los[ch] = tmr_exp_q[ch*3];
		assign no8[ch] = tmr_exp_q[ch*3+1];
		assign no4[ch] = tmr_exp_q[ch*3+2];
		assign tmr_restart[ch*3] = evt[ch].pulse; // R6
		assign tmr_restart[ch*3+1] = evt[ch].bpv; // R11
		// removed markers only mean something with the 8kHz present
		assign tmr_restart[ch*3+2] = evt[ch].omit & ~no8[ch]; // R13

		// omitted marker keeps the 8kHz grid for the 400Hz variant
		assign marker[ch] = evt[ch].bpv | evt[ch].omit; // R3
		assign fall[ch] = ctrl_q.edge_sel[ch] ?
			(evt[ch].pulse & ~marker[ch] & after_q[ch]) :
			marker[ch]; // R4
		// a second fall while low would stretch the low half
		assign fall_ok[ch] = fall[ch] & clk8_q[ch]; // R3

		always_ff @(posedge ref_clk or posedge reset) begin
			if (reset) begin
				after_q[ch] <= 1'b0;
			end else if (marker[ch]) begin
				after_q[ch] <= 1'b1;
			end else if (evt[ch].pulse) begin
				after_q[ch] <= 1'b0;
			end
		end

		// low half-period runs from the fall, then high until next fall
		always_ff @(posedge ref_clk or posedge reset) begin
			if (reset) begin
				clk8_q[ch] <= 1'b1;
				half_q <= 32'h0000_0000;
			end else if (fall_ok[ch]) begin
				clk8_q[ch] <= 1'b0;
				half_q <= 32'h0000_0000;
			end else if (~clk8_q[ch]) begin
				if (half_q == HALF_CYC - 1) begin
					clk8_q[ch] <= 1'b1;
				end else begin
					half_q <= half_q + 32'h0000_0001;
				end
			end
		end

		// held high, so the monitor sees no edges with 8kHz gone
		always_ff @(posedge ref_clk or posedge reset) begin
			if (reset) begin
				recovered_clk[ch] <= 1'b1;
			end else begin
				recovered_clk[ch] <= clk8_q[ch] | no8[ch]; // R12
			end
		end

		// missing 400Hz deliberately plays no part here
		always_ff @(posedge ref_clk or posedge reset) begin
			if (reset) begin
				clock_invalid[ch] <= 1'b0;
			end else begin
				clock_invalid[ch] <= no8[ch] // R12 R15
					| (ctrl_q.los_inv & los[ch]) // R10
					| (ctrl_q.ami_inv & ami_act[ch]); // R9
			end
		end

		always_ff @(posedge ref_clk or posedge reset) begin
			if (reset) begin
				bucket_inc[ch] <= 1'b0;
			end else if (ctrl_q.sgl_cnt) begin
				bucket_inc[ch] <= evt[ch].brk; // R8
			end else begin
				bucket_inc[ch] <= evt[ch].ami;
			end
		end
	end

	// absence timers: los, no-8kHz, no-400Hz per line
	for (genvar k = 0; k < NT; k++) begin : g_tmr
		localparam int unsigned LIM = (k % 3 == 0) ? LOS_CYC :
			(k % 3 == 1) ? NO8_CYC : NO4_CYC;
		logic [31:0] cnt_q;

		// free running by design: these detectors cannot be switched off
		always_ff @(posedge ref_clk or posedge reset) begin
			if (reset) begin
				cnt_q <= 32'h0000_0000;
				tmr_exp_q[k] <= 1'b0;
			end else if (tmr_restart[k]) begin
				cnt_q <= 32'h0000_0000;
				tmr_exp_q[k] <= 1'b0;
			end else if (cnt_q == LIM - 1) begin
				tmr_exp_q[k] <= 1'b1; // R6 R11 R13
			end else begin
				cnt_q <= cnt_q + 32'h0000_0001;
			end
		end
	end

	// write decode
	assign wr_ctrl = reg_wr & (reg_addr == AW'(`CCR_OFS_CTRL));
	assign wr_lf_clr = reg_wr & (reg_addr == AW'(`CCR_OFS_LF_CLR));
	assign wr_lf_en = reg_wr & (reg_addr == AW'(`CCR_OFS_LF_EN));
	assign wr_cl_clr = reg_wr & (reg_addr == AW'(`CCR_OFS_CL_CLR));
	assign wr_cl_en = reg_wr & (reg_addr == AW'(`CCR_OFS_CL_EN));

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ctrl_q <= `CCR_CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl_q.edge_sel <= reg_wdata[`CCR_CTRL_EDGE +: 2]; // R4
			ctrl_q.sgl_cnt <= reg_wdata[`CCR_CTRL_SGL]; // R8
			ctrl_q.ami_inv <= reg_wdata[`CCR_CTRL_AMI_INV]; // R9
			ctrl_q.los_inv <= reg_wdata[`CCR_CTRL_LOS_INV]; // R10
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			lf_en_q <= 4'h0;
		end else if (wr_lf_en) begin
			lf_en_q <= reg_wdata[3:0];
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cl_en_q <= 4'h0;
		end else if (wr_cl_en) begin
			cl_en_q <= reg_wdata[3:0];
		end
	end

	// conditions that persist keep setting their flag; set beats clear
	always_comb begin
		lf_set = 4'h0;
		lf_set[`CCR_LF_LOS +: 2] = los; // R5
		lf_set[`CCR_LF_AMI +: 2] = ami_evt; // R5 R14
	end

	always_comb begin
		cl_set = 4'h0;
		cl_set[`CCR_CL_NO8 +: 2] = no8; // R11
		cl_set[`CCR_CL_NO4 +: 2] = no4; // R13
	end

	// clear masks exist only in the cycle of the write
	always_comb begin
		lf_clr = 4'h0;
		if (wr_lf_clr) begin
			lf_clr = reg_wdata[3:0];
		end
	end

	always_comb begin
		cl_clr = 4'h0;
		if (wr_cl_clr) begin
			cl_clr = reg_wdata[3:0];
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			lf_stat_q <= 4'h0;
		end else begin
			lf_stat_q <= (lf_stat_q & ~lf_clr) | lf_set; // R5 R18
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cl_stat_q <= 4'h0;
		end else begin
			cl_stat_q <= (cl_stat_q & ~cl_clr) | cl_set; // R18
		end
	end

	// one level request for all enabled flags
	assign lf_irq = |(lf_stat_q & lf_en_q); // R5 R18
	assign cl_irq = |(cl_stat_q & cl_en_q); // R11 R13

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			interrupt_request_pin <= 1'b0;
		end else begin
			interrupt_request_pin <= lf_irq | cl_irq;
		end
	end

	// live conditions and control fields packed for read back
	always_comb begin
		live = 8'h00;
		live[`CCR_LIVE_LOS +: 2] = los;
		live[`CCR_LIVE_AMI +: 2] = ami_act;
		live[`CCR_LIVE_NO8 +: 2] = no8;
		live[`CCR_LIVE_NO4 +: 2] = no4;
	end

	always_comb begin
		ctrl_rd = 5'h00;
		ctrl_rd[`CCR_CTRL_EDGE +: 2] = ctrl_q.edge_sel;
		ctrl_rd[`CCR_CTRL_SGL] = ctrl_q.sgl_cnt;
		ctrl_rd[`CCR_CTRL_AMI_INV] = ctrl_q.ami_inv;
		ctrl_rd[`CCR_CTRL_LOS_INV] = ctrl_q.los_inv;
	end

	// read mux; clear registers are write-only and read zero
	always_comb begin
		rd_mux = '0;
		case (reg_addr)
			AW'(`CCR_OFS_CTRL): begin
				rd_mux[4:0] = ctrl_rd;
			end
			AW'(`CCR_OFS_LF_STAT): begin
				rd_mux[3:0] = lf_stat_q;
			end
			AW'(`CCR_OFS_LF_EN): begin
				rd_mux[3:0] = lf_en_q;
			end
			AW'(`CCR_OFS_CL_STAT): begin
				rd_mux[3:0] = cl_stat_q;
			end
			AW'(`CCR_OFS_CL_EN): begin
				rd_mux[3:0] = cl_en_q;
			end
			AW'(`CCR_OFS_LIVE): begin
				rd_mux[7:0] = live;
			end
			default: begin
				rd_mux = '0;
			end
		endcase
	end

	// data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end else begin
			reg_rdata <= '0;
		end
	end
endmodule : ccr_receiver_monitor

// ---- hdl/ccr_map.svh ----
// register map, field positions and timing figures of the receiver monitor
`ifndef CCR_MAP_SVH
`define CCR_MAP_SVH
`define CCR_OFS_CTRL 8'h00
`define CCR_OFS_LF_STAT 8'h04
`define CCR_OFS_LF_CLR 8'h08
`define CCR_OFS_LF_EN 8'h0C
`define CCR_OFS_CL_STAT 8'h10
`define CCR_OFS_CL_CLR 8'h14
`define CCR_OFS_CL_EN 8'h18
`define CCR_OFS_LIVE 8'h1C
`define CCR_CTRL_EDGE 0
`define CCR_CTRL_SGL 2
`define CCR_CTRL_AMI_INV 3
`define CCR_CTRL_LOS_INV 4
`define CCR_CTRL_RST 5'h00
`define CCR_LF_LOS 0
`define CCR_LF_AMI 2
`define CCR_CL_NO8 0
`define CCR_CL_NO4 2
`define CCR_LIVE_LOS 0
`define CCR_LIVE_AMI 2
`define CCR_LIVE_NO8 4
`define CCR_LIVE_NO4 6
`define CCR_MARKS 3'h7
`define CCR_REF_HZ 200000000
`define CCR_FRAME_HZ 8000
`define CCR_LOS_US 32
`define CCR_NO8_US 500
`define CCR_NO4_MS 5
`endif

// ---- hdl/ccr_pkg.sv ----
// types shared by the receiver monitor files
package ccr_pkg;
	typedef struct packed {
		logic pulse;
		logic bpv;
		logic omit;
		logic brk;
		logic ami;
		logic ami_act;
	} ccr_evt_s;
	typedef struct packed {
		logic los_inv;
		logic ami_inv;
		logic sgl_cnt;
		logic [1:0] edge_sel;
	} ccr_ctrl_s;
endpackage : ccr_pkg

// ---- hdl/ccr_line_decode.sv ----
// one composite clock line: pulse, violation and pattern decoding
`timescale 1ns/1ps
`include "ccr_map.svh"
module ccr_line_decode (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// comparator levels of the line
	input wire logic line_pos,
	input wire logic line_neg,
	// decoded events
	output ccr_pkg::ccr_evt_s evt_q
);
	logic [2:0] pos_sync_q;
	logic [2:0] neg_sync_q;
	logic last_pol_q;
	logic seen_q;
	logic [2:0] mark_cnt_q;
	logic prev_brk_q;
	logic pos_rise, neg_rise, start, same_pol, is_bpv, is_norm;
	logic full, omit, brk, per_end;

	// stage 0 feeds stage 1 only; stage 2 is the edge history
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pos_sync_q <= 3'h0;
			neg_sync_q <= 3'h0;
		end else begin
			pos_sync_q <= {pos_sync_q[1:0], line_pos};
			neg_sync_q <= {neg_sync_q[1:0], line_neg};
		end
	end

	assign pos_rise = pos_sync_q[1] & ~pos_sync_q[2];
	assign neg_rise = neg_sync_q[1] & ~neg_sync_q[2];
	assign start = pos_rise | neg_rise;
	assign same_pol = seen_q & (pos_rise == last_pol_q);
	assign is_bpv = start & same_pol; // R1
	assign is_norm = start & ~same_pol;
	assign full = (mark_cnt_q == `CCR_MARKS);
	// eighth mark without violation: removed marker
	assign omit = is_norm & full; // R2
	assign brk = (is_bpv & ~full) | omit; // R7
	assign per_end = is_bpv | omit;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			last_pol_q <= 1'b0;
			seen_q <= 1'b0;
		end else if (start) begin
			last_pol_q <= pos_rise;
			seen_q <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			mark_cnt_q <= 3'h0;
		end else if (per_end) begin
			mark_cnt_q <= 3'h0;
		end else if (is_norm) begin
			mark_cnt_q <= mark_cnt_q + 3'h1;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			prev_brk_q <= 1'b0;
		end else if (per_end) begin
			prev_brk_q <= brk;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			evt_q <= '0;
		end else begin
			evt_q.pulse <= start;
			evt_q.bpv <= is_bpv;
			evt_q.omit <= omit;
			evt_q.brk <= per_end & brk; // R8
			evt_q.ami <= per_end & brk & prev_brk_q; // R7
			if (per_end & brk & prev_brk_q) begin
				evt_q.ami_act <= 1'b1;
			end else if (per_end & ~brk) begin
				evt_q.ami_act <= 1'b0;
			end
		end
	end
endmodule : ccr_line_decode

// ---- bench/ccr_monitor_sva.sv ----
// assertion checker on the receiver monitor ports
`timescale 1ns/1ps
module ccr_monitor_sva #(
	parameter int AW = 8,
	parameter int DW = 8,
	parameter int unsigned LOS_CYC = 64,
	parameter int unsigned NO8_CYC = 400,
	parameter int unsigned HALF_CYC = 16
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// line one
	input wire logic composite_input_one_pos,
	input wire logic composite_input_one_neg,
	// register port
	input wire logic [AW-1:0] reg_addr,
	input wire logic [DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [DW-1:0] reg_rdata,
	// outputs
	input wire logic [1:0] recovered_clk,
	input wire logic [1:0] clock_invalid,
	input wire logic [1:0] bucket_inc,
	input wire logic interrupt_request_pin
);
	logic [DW-1:0] ctrl_q;
	logic [DW-1:0] lf_en_q;
	logic [DW-1:0] cl_en_q;
	logic [31:0] idle_q;
	logic [31:0] low_q;
	logic [2:0] mask_age_q;
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ctrl_q <= '0;
			lf_en_q <= '0;
			cl_en_q <= '0;
		end else if (reg_wr) begin
			if (reg_addr == AW'(8'h00))
				ctrl_q <= reg_wdata;
			if (reg_addr == AW'(8'h0C))
				lf_en_q <= reg_wdata & DW'(8'h0F);
			if (reg_addr == AW'(8'h18))
				cl_en_q <= reg_wdata & DW'(8'h0F);
		end
	end
	// idle counts from the end of the last mark, so it lags the decoder
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			idle_q <= '0;
			low_q <= '0;
			mask_age_q <= '0;
		end else begin
			idle_q <= (composite_input_one_pos || composite_input_one_neg) ? '0 : idle_q + 1;
			low_q <= recovered_clk[0] ? '0 : low_q + 1;
			if (lf_en_q != '0 || cl_en_q != '0)
				mask_age_q <= '0;
			else if (mask_age_q != 3'h7)
				mask_age_q <= mask_age_q + 3'h1;
		end
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data not idle");
	a_wo_zero: assert property ((reg_rd && reg_addr == AW'(8'h08)) |=> reg_rdata == '0)
		else $error("clear register read back");
	a_en_readback: assert property ((reg_rd && reg_addr == AW'(8'h0C)) |=>
		reg_rdata == $past(lf_en_q)) else $error("enable read back");
	a_los_inval: assert property ((ctrl_q[4] && $past(ctrl_q[4], 3) &&
		idle_q > LOS_CYC + 10) |-> clock_invalid[0]) else $error("los not invalid");
	a_no8_idle: assert property ((idle_q > NO8_CYC + 10) |->
		recovered_clk[0] && clock_invalid[0]) else $error("clock without markers");
	a_half_width: assert property ($rose(recovered_clk[0]) |-> low_q == HALF_CYC)
		else $error("clock low time");
	a_irq_hold: assert property ($fell(interrupt_request_pin) |->
		$past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3)) else $error("irq dropped");
	a_irq_masked: assert property ((mask_age_q > 3'h3) |-> !interrupt_request_pin)
		else $error("irq while masked");
	a_bucket_pulse: assert property (bucket_inc[0] |=> !bucket_inc[0])
		else $error("bucket pulse long");
	c_irq: cover property ($rose(interrupt_request_pin));
	c_bucket: cover property (bucket_inc[0]);
	c_clk_two: cover property ($fell(recovered_clk[1]));
endmodule : ccr_monitor_sva
bind ccr_receiver_monitor ccr_monitor_sva #(.AW(AW), .DW(DW), .LOS_CYC(LOS_CYC),
	.NO8_CYC(NO8_CYC), .HALF_CYC(HALF_CYC)) u_sva (.ref_clk(ref_clk), .reset(reset),
	.composite_input_one_pos(composite_input_one_pos),
	.composite_input_one_neg(composite_input_one_neg), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.recovered_clk(recovered_clk), .clock_invalid(clock_invalid), .bucket_inc(bucket_inc),
	.interrupt_request_pin(interrupt_request_pin));

// ---- bench/ccr_line_src.sv ----
// composite clock line source for one receiver input
`timescale 1ns/1ps
module ccr_line_src #(
	parameter int BIT = 12,
	parameter int WID = 6,
	parameter int OMIT = 20
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// 0 normal, 1 no marker, 2 silent, 3 marker dropped every OMIT frames
	input wire logic [1:0] mode,
	// comparator levels
	output logic pos,
	output logic neg,
	output logic bpv_o
);
	int ph;
	int frm;
	logic [2:0] slot;
	logic last;
	logic viol;
	logic nxt;
	assign viol = slot == 3'h7 && (mode == 2'h0 || (mode == 2'h3 && frm != 0));
	assign nxt = viol ? last : !last;
	// a silent line shows no mark on either comparator
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ph <= 0;
			frm <= 0;
			slot <= '0;
			last <= 1'b0;
			pos <= 1'b0;
			neg <= 1'b0;
			bpv_o <= 1'b0;
		end else begin
			bpv_o <= 1'b0;
			ph <= (ph == BIT - 1) ? 0 : ph + 1;
			if (ph == 0) begin
				slot <= slot + 3'h1;
				if (slot == 3'h7)
					frm <= (frm == OMIT - 1) ? 0 : frm + 1;
				if (mode != 2'h2) begin
					pos <= nxt;
					neg <= !nxt;
					last <= nxt;
					bpv_o <= viol;
				end
			end else if (ph == WID) begin
				pos <= 1'b0;
				neg <= 1'b0;
			end
		end
	end
endmodule : ccr_line_src

// ---- bench/tb.sv ----
// self-checking bench of the receiver monitor
`timescale 1ns/1ps
module tb;
	localparam int BIT = 12;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] reg_addr = '0;
	logic [7:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [1:0] mode1 = 2'h3;
	logic [1:0] mode2 = 2'h0;
	logic [7:0] reg_rdata, rv;
	logic [1:0] rclk, cinv, binc;
	logic irq, p1, n1, p2, n2, bpv1;
	logic [7:0] offs [6] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h18, 8'h1C};
	int err_count = 0;
	int n_checks = 0;
	int d0, d1, k;
	always #2.5 ref_clk = ~ref_clk;
	ccr_line_src #(.BIT(BIT)) u_src1 (.ref_clk(ref_clk), .reset(reset), .mode(mode1),
		.pos(p1), .neg(n1), .bpv_o(bpv1));
	ccr_line_src #(.BIT(BIT)) u_src2 (.ref_clk(ref_clk), .reset(reset), .mode(mode2),
		.pos(p2), .neg(n2), .bpv_o());
	ccr_receiver_monitor #(.LOS_CYC(64), .NO8_CYC(400), .NO4_CYC(4000), .HALF_CYC(16)) u_dut (
		.ref_clk(ref_clk), .reset(reset), .composite_input_one_pos(p1),
		.composite_input_one_neg(n1), .composite_input_two_pos(p2),
		.composite_input_two_neg(n2), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .recovered_clk(rclk),
		.clock_invalid(cinv), .bucket_inc(binc), .interrupt_request_pin(irq));
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			err_count++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		rv = reg_rdata;
		chk(nm, e, rv & m);
	endtask : rchk
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	// expected read back of an enable register: four defined bits
	function automatic logic [7:0] en_layout(input logic [7:0] d);
		en_layout = d & 8'h0F;
	endfunction : en_layout
	// counts clock falls of line ch, or bucket pulses when sel is set
	task automatic count(input int n, input logic sel, input int ch, output int c);
		logic prev;
		c = 0;
		prev = rclk[ch];
		repeat (n) begin
			@(posedge ref_clk);
			#1;
			if (sel ? binc[ch] === 1'b1 : (prev === 1'b1 && rclk[ch] === 1'b0))
				c++;
			prev = rclk[ch];
		end
	endtask : count
	task automatic gap(output int d);
		int i;
		i = 0;
		d = 0;
		cyc(1);
		while (bpv1 !== 1'b1 && i < 300) begin
			cyc(1);
			i++;
		end
		while (rclk[0] !== 1'b0 && d < 300) begin
			cyc(1);
			d++;
		end
		if (i >= 300 || d >= 300) begin
			err_count++;
			complete_run();
		end
	endtask : gap
	initial begin
		k = $urandom(32'h2e78);
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		foreach (offs[i])
			rchk("reset value", offs[i], 8'hFF, 8'h00);
		chk("irq", 8'h00, {7'h0, irq});
		$display("test 1 done");
		k = $urandom;
		wr(8'h0C, k[7:0]);
		rchk("enable", 8'h0C, 8'hFF, en_layout(k[7:0]));
		k = $urandom_range(255, 32);
		rchk("unmapped", k[7:0], 8'hFF, 8'h00);
		rchk("clear reg", 8'h08, 8'hFF, 8'h00);
		wr(8'h0C, 8'h00);
		wr(8'h18, 8'h00);
		cyc(1200);
		wr(8'h08, 8'hFF);
		wr(8'h14, 8'hFF);
		cyc(300);
		rchk("line faults", 8'h04, 8'hFF, 8'h00);
		$display("test 2 done");
		wr(8'h00, 8'h00);
		gap(d0);
		wr(8'h00, 8'h01);
		gap(d1);
		chk("edge gap", 8'(BIT), 8'(d1 - d0));
		count(960, 1'b0, 0, k);
		chk("clock edges", 8'h0A, 8'(k));
		count(960, 1'b0, 1, k);
		chk("clock edges two", 8'h0A, 8'(k));
		cyc(4200);
		wr(8'h14, 8'hFF);
		cyc(4100);
		rchk("component loss", 8'h10, 8'hFF, 8'h08);
		$display("test 3 done");
		wr(8'h00, 8'h0C);
		wr(8'h08, 8'hFF);
		count(3840, 1'b1, 0, k);
		chk("bucket", 8'h02, 8'(k));
		count(960, 1'b1, 1, k);
		chk("bucket two", 8'h00, 8'(k));
		rchk("line faults", 8'h04, 8'hFF, 8'h00);
		chk("invalid", 8'h00, {6'h0, cinv});
		$display("test 4 done");
		mode1 <= 2'h1;
		wr(8'h18, 8'h01);
		cyc(600);
		chk("irq", 8'h01, {7'h0, irq});
		rchk("no frame tone", 8'h10, 8'h01, 8'h01);
		chk("invalid", 8'h01, {7'h0, cinv[0]});
		count(200, 1'b0, 0, k);
		chk("clock edges", 8'h00, 8'(k));
		wr(8'h08, 8'hFF);
		cyc(200);
		rchk("ami again", 8'h04, 8'h04, 8'h04);
		wr(8'h18, 8'h00);
		cyc(3);
		chk("irq", 8'h00, {7'h0, irq});
		wr(8'h0C, 8'h04);
		cyc(3);
		chk("irq", 8'h01, {7'h0, irq});
		wr(8'h0C, 8'h00);
		$display("test 5 done");
		mode1 <= 2'h2;
		wr(8'h00, 8'h10);
		cyc(500);
		rchk("los", 8'h04, 8'h01, 8'h01);
		chk("invalid", 8'h01, {6'h0, cinv});
		$display("test 6 done");
		complete_run();
	end
endmodule : tb
